//--- pkg/agc_pkg.sv
// package: page codes, register offsets, field positions and reset values of the config bank
package agc_pkg;
    // page selection
    localparam logic [23:0] PAGE_ANALOG      = 24'h0000FF;
    localparam logic [23:0] PAGE_DIGFUNC_A   = 24'h610000;
    localparam logic [23:0] PAGE_DIGFUNC_B   = 24'h610100;
    // register offsets within a page
    localparam logic [11:0] OFS_EST_SOURCE   = 12'h034;
    localparam logic [11:0] OFS_LOW_RATE_1   = 12'h03F;
    localparam logic [11:0] OFS_LOW_RATE_2   = 12'h042;
    localparam logic [11:0] OFS_CORR_CTRL    = 12'h068;
    localparam logic [11:0] OFS_GAIN_CTRL    = 12'h0A6;
    // field positions
    localparam int          POS_EXT_EST      = 0;
    localparam int          POS_LOW_RATE_1   = 2;
    localparam int          POS_LOW_RATE_2   = 4;
    localparam int          POS_FREEZE       = 7;
    localparam int          POS_WR1_HI       = 5;
    localparam int          POS_DISABLE      = 2;
    localparam int          POS_WR1_LO       = 1;
    localparam int          POS_CTRL_BIT0    = 0;
    localparam int          GAIN_WIDTH       = 4;
    // corrector control writable mask (bits 7,5,2,1,0)
    localparam logic [7:0]  CORR_RW_MASK     = 8'hA7;
    // largest legal gain code (11 dB)
    localparam logic [3:0]  GAIN_MAX_CODE    = 4'hB;
    // reset values
    localparam logic [7:0]  RST_REG          = 8'h00;
    // corrector operating states
    typedef enum logic [1:0] {
        AGC_CORR_DISABLED,
        AGC_CORR_TRACKING,
        AGC_CORR_FROZEN,
        AGC_CORR_INVALID
    } agc_corr_mode_type;
endpackage : agc_pkg

//--- logic/agc_config_regs.sv
// config bank: low-rate selects, per-channel gain and channel A offset corrector controls
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////
module agc_config_regs #(
    parameter int NUM_CHANNELS = 2
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    // register access port, page already resolved by the serial front end
    input  wire logic [23:0]             page_i,
    input  wire logic                    page_type_i,
    input  wire logic [11:0]             addr_i,
    input  wire logic                    wr_en_i,
    input  wire logic [7:0]              wr_data_i,
    input  wire logic                    rd_en_i,
    output logic      [7:0]              rd_data_o,
    output logic                         rd_valid_o,
    // sampler configuration
    output logic                         low_rate_sel_first_o,
    output logic                         low_rate_sel_second_o,
    // per-channel gain codes, channel A in the low nibble
    output logic [4*NUM_CHANNELS-1:0]    output_gain_code_o,
    // channel A offset corrector
    output logic                         external_estimate_select_o,
    output logic                         offset_block_disable_o,
    output logic                         corr_freeze_o,
    output logic                         corr_estimate_run_o,
    output logic                         corr_setting_illegal_o
);
    // the read mux and page decode serve exactly two channel pages
    if (NUM_CHANNELS != 2) begin : g_bad_channels
        $error("agc_config_regs supports exactly two channels");
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // page decode
    logic       in_analog;
    logic       in_corr_a;
    logic [NUM_CHANNELS-1:0] in_gain;
    assign in_analog = !page_type_i && (page_i[7:0] == agc_pkg::PAGE_ANALOG[7:0]);
    assign in_corr_a = page_type_i && (page_i == agc_pkg::PAGE_DIGFUNC_A);
    assign in_gain[0] = page_type_i && (page_i == agc_pkg::PAGE_DIGFUNC_A);
    assign in_gain[1] = page_type_i && (page_i == agc_pkg::PAGE_DIGFUNC_B);

    //////////////////////////////////////////////////////////////////////////////////////
    // storage; reserved bits are not stored or are masked to zero on write, so they always read zero
    logic       low_rate_1;
    logic       low_rate_2;
    logic       ext_est;
    logic [7:0] corr_ctrl;
    logic [3:0] gain [NUM_CHANNELS];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            low_rate_1 <= agc_pkg::RST_REG[agc_pkg::POS_LOW_RATE_1];
            low_rate_2 <= agc_pkg::RST_REG[agc_pkg::POS_LOW_RATE_2];
        end else if (wr_en_i && in_analog) begin
            if (addr_i == agc_pkg::OFS_LOW_RATE_1) begin
                low_rate_1 <= wr_data_i[agc_pkg::POS_LOW_RATE_1];
            end
            if (addr_i == agc_pkg::OFS_LOW_RATE_2) begin
                low_rate_2 <= wr_data_i[agc_pkg::POS_LOW_RATE_2];
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ext_est   <= agc_pkg::RST_REG[agc_pkg::POS_EXT_EST];
            corr_ctrl <= agc_pkg::RST_REG;
        end else if (wr_en_i && in_corr_a) begin
            if (addr_i == agc_pkg::OFS_EST_SOURCE) begin
                ext_est <= wr_data_i[agc_pkg::POS_EXT_EST];
            end
            if (addr_i == agc_pkg::OFS_CORR_CTRL) begin
                corr_ctrl <= wr_data_i & agc_pkg::CORR_RW_MASK;
            end
        end
    end

    // gain codes above 11 dB are stored as written; the datapath treats them as undefined
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_gain
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                gain[ch] <= agc_pkg::RST_REG[3:0];
            end else if (wr_en_i && in_gain[ch] && addr_i == agc_pkg::OFS_GAIN_CTRL) begin
                gain[ch] <= wr_data_i[agc_pkg::GAIN_WIDTH-1:0];
            end
        end
        assign output_gain_code_o[4*ch +: 4] = gain[ch];
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // corrector mode from bits 7,5,1 and the disable bit
    agc_pkg::agc_corr_mode_type corr_mode;
    logic [2:0] frz_bits;
    assign frz_bits = {corr_ctrl[agc_pkg::POS_FREEZE], corr_ctrl[agc_pkg::POS_WR1_HI],
                       corr_ctrl[agc_pkg::POS_WR1_LO]};

    always_comb begin
        if (corr_ctrl[agc_pkg::POS_DISABLE]) begin
            corr_mode = agc_pkg::AGC_CORR_DISABLED;
        end else begin
            case (frz_bits)
                3'h3:    corr_mode = agc_pkg::AGC_CORR_TRACKING;
                3'h7:    corr_mode = agc_pkg::AGC_CORR_FROZEN;
                default: corr_mode = agc_pkg::AGC_CORR_INVALID;
            endcase
        end
    end

    assign low_rate_sel_first_o       = low_rate_1;
    assign low_rate_sel_second_o      = low_rate_2;
    assign external_estimate_select_o = ext_est;
    assign offset_block_disable_o     = corr_ctrl[agc_pkg::POS_DISABLE];
    assign corr_freeze_o              = (corr_mode == agc_pkg::AGC_CORR_FROZEN);
    assign corr_estimate_run_o        = (corr_mode == agc_pkg::AGC_CORR_TRACKING);
    assign corr_setting_illegal_o     = (corr_mode == agc_pkg::AGC_CORR_INVALID);

    //////////////////////////////////////////////////////////////////////////////////////
    // read-back, one cycle after the request, unmapped reads give zero
    logic [7:0] next_rd_data;
    always_comb begin
        next_rd_data = 8'h00;
        if (in_analog && addr_i == agc_pkg::OFS_LOW_RATE_1) begin
            next_rd_data[agc_pkg::POS_LOW_RATE_1] = low_rate_1;
        end else if (in_analog && addr_i == agc_pkg::OFS_LOW_RATE_2) begin
            next_rd_data[agc_pkg::POS_LOW_RATE_2] = low_rate_2;
        end else if (in_corr_a && addr_i == agc_pkg::OFS_EST_SOURCE) begin
            next_rd_data[agc_pkg::POS_EXT_EST] = ext_est;
        end else if (in_corr_a && addr_i == agc_pkg::OFS_CORR_CTRL) begin
            next_rd_data = corr_ctrl;
        end else if (in_gain[0] && addr_i == agc_pkg::OFS_GAIN_CTRL) begin
            next_rd_data[3:0] = gain[0];
        end else if (in_gain[1] && addr_i == agc_pkg::OFS_GAIN_CTRL) begin
            next_rd_data[3:0] = gain[1];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_data_o  <= rd_en_i ? next_rd_data : rd_data_o;
            rd_valid_o <= rd_en_i;
        end
    end
endmodule : agc_config_regs

//--- verif/agc_config_regs_asserts.sv
// concurrent checks on the config bank ports
`timescale 1ns/1ps
module agc_config_regs_asserts #(parameter int NUM_CHANNELS = 2) (
    input wire logic clk_i, sys_rst_i, page_type_i, wr_en_i,
    input wire logic [23:0] page_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [4*NUM_CHANNELS-1:0] output_gain_code_o,
    input wire logic low_rate_sel_first_o, low_rate_sel_second_o, external_estimate_select_o,
    input wire logic offset_block_disable_o, corr_freeze_o, corr_estimate_run_o,
    input wire logic corr_setting_illegal_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire an = wr_en_i && !page_type_i && page_i[7:0] == 8'hFF;
    wire da = wr_en_i && page_type_i && page_i == 24'h610000;
    wire db = wr_en_i && page_type_i && page_i == 24'h610100;
    wire c = da && addr_i == 12'h068;
    wire [2:0] f = {wr_data_i[7], wr_data_i[5], wr_data_i[1]};
    property p_lr1; an && addr_i == 12'h03F |=> low_rate_sel_first_o == $past(wr_data_i[2]); endproperty
    a_lr1: assert property (p_lr1) else $error("first low-rate bit");
    property p_lr2; an && addr_i == 12'h042 |=> low_rate_sel_second_o == $past(wr_data_i[4]); endproperty
    a_lr2: assert property (p_lr2) else $error("second low-rate bit");
    property p_gna; da && addr_i == 12'h0A6 |=> output_gain_code_o[3:0] == $past(wr_data_i[3:0]); endproperty
    a_gna: assert property (p_gna) else $error("gain A");
    property p_gnb; db && addr_i == 12'h0A6 |=> output_gain_code_o[7:4] == $past(wr_data_i[3:0]); endproperty
    a_gnb: assert property (p_gnb) else $error("gain B");
    property p_ext; da && addr_i == 12'h034 |=> external_estimate_select_o == $past(wr_data_i[0]); endproperty
    a_ext: assert property (p_ext) else $error("estimate select");
    property p_dis; c |=> offset_block_disable_o == $past(wr_data_i[2]); endproperty
    a_dis: assert property (p_dis) else $error("disable bit");
    property p_frz; c |=> corr_freeze_o == $past(!wr_data_i[2] && f == 3'h7); endproperty
    a_frz: assert property (p_frz) else $error("freeze decode");
    property p_run; c |=> corr_estimate_run_o == $past(!wr_data_i[2] && f == 3'h3); endproperty
    a_run: assert property (p_run) else $error("run decode");
    // disable wins, otherwise exactly one corrector state
    property p_one; $countones({corr_freeze_o, corr_estimate_run_o, corr_setting_illegal_o})
        == 32'(!offset_block_disable_o); endproperty
    a_one: assert property (p_one) else $error("corrector state");
    c_frz: cover property (corr_freeze_o);
    c_run: cover property (corr_estimate_run_o);
    c_dis: cover property (offset_block_disable_o);
endmodule : agc_config_regs_asserts
bind agc_config_regs agc_config_regs_asserts #(.NUM_CHANNELS(NUM_CHANNELS)) chk_u (.*);

//--- verif/test_agc_config_regs.sv
// self-checking bench for the config bank
`timescale 1ns/1ps
module test_agc_config_regs;
    logic clk_i = 0, sys_rst_i = 1, page_type_i = 0, wr_en_i = 0, rd_en_i = 0;
    logic [23:0] page_i = 0;
    logic [11:0] addr_i = 0;
    logic [7:0] wr_data_i = 0, rd_data_o, gain;
    logic rd_valid_o, l1, l2, ext, dis, frz, run, ill;
    int errors = 0, comparisons = 0;
    logic [7:0] mdl [logic [36:0]];
    // last entry is unmapped: channel B has no corrector registers
    logic [36:0] regs [7] = '{{1'b0, 24'hFF, 12'h03F}, {1'b0, 24'hFF, 12'h042},
        {1'b1, 24'h610000, 12'h034}, {1'b1, 24'h610000, 12'h068}, {1'b1, 24'h610000, 12'h0A6},
        {1'b1, 24'h610100, 12'h0A6}, {1'b1, 24'h610100, 12'h068}};
    logic [7:0] msks [7] = '{8'h04, 8'h10, 8'h01, 8'hA7, 8'h0F, 8'h0F, 8'h00};
    wire [15:0] outv = {1'b0, l1, l2, gain, ext, dis, frz, run, ill};
    agc_config_regs dut_u (.clk_i, .sys_rst_i, .page_i, .page_type_i, .addr_i, .wr_en_i,
        .wr_data_i, .rd_en_i, .rd_data_o, .rd_valid_o, .low_rate_sel_first_o(l1),
        .low_rate_sel_second_o(l2), .output_gain_code_o(gain), .external_estimate_select_o(ext),
        .offset_block_disable_o(dis), .corr_freeze_o(frz), .corr_estimate_run_o(run),
        .corr_setting_illegal_o(ill));
    initial forever #25 clk_i = ~clk_i;
    function automatic logic [15:0] expo();
        logic [7:0] c;
        logic [2:0] f;
        c = mdl[regs[3]];
        f = {c[7], c[5], c[1]};
        return {1'b0, mdl[regs[0]][2], mdl[regs[1]][4], mdl[regs[5]][3:0], mdl[regs[4]][3:0],
            mdl[regs[2]][0], c[2], !c[2] && f == 3'h7, !c[2] && f == 3'h3,
            !c[2] && f != 3'h7 && f != 3'h3};
    endfunction : expo
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(int i, logic [7:0] d, logic w);
        @(posedge clk_i);
        #2 {page_type_i, page_i, addr_i} = regs[i];
        wr_data_i = d;
        wr_en_i = w;
        rd_en_i = !w;
        @(posedge clk_i);
        #2 wr_en_i = 0;
        rd_en_i = 0;
        if (w) mdl[regs[i]] = d & msks[i];
        else chk({7'h0, rd_valid_o, rd_data_o}, {8'h01, mdl[regs[i]]});
    endtask : acc
    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial begin
        int i;
        logic [7:0] d;
        for (int k = 0; k < 7; k++) mdl[regs[k]] = 8'h00;
        repeat (3) @(posedge clk_i);
        #2 sys_rst_i = 0;
        void'($urandom(38));
        chk(outv, expo());
        for (int k = 0; k < 7; k++) acc(k, 8'h00, 0);
        acc(3, 8'h22, 1);
        chk(outv, expo());
        acc(0, 8'h04, 1);
        acc(1, 8'h10, 1);
        // every freeze and disable combination, 011 and 111 among them
        for (int v = 0; v < 16; v++) begin
            acc(3, {v[3], 1'b0, v[2], 2'h0, v[1], v[0], 1'b1}, 1);
            chk(outv, expo());
            acc(3, 8'h00, 0);
        end
        for (int n = 0; n < 80; n++) begin
            i = $urandom_range(6);
            d = 8'($urandom) & msks[i];
            if (i == 3) d = d | 8'h22;
            if (i == 4 || i == 5) d = 8'($urandom_range(11));
            acc(i, d, 1);
            acc(i, 8'h00, 0);
            chk(outv, expo());
        end
        test_done();
    end
    initial begin
        #100us errors++;
        test_done();
    end
endmodule : test_agc_config_regs
